//--- tx_seq_device.sv
// How it works
// - CRC bit appends CRC, else checks last four
// - Override selects control byte over config register
// - Start pointer at control byte, end at last
// - Host should prefer even start pointer
// - Host writes control byte, header, payload first
// - Host clears done flag, enables, then requests
// - Transmit waits while DMA is running
// - DMA waits until transmit request clears
// - Host leaves config and frame bytes alone
// - Clearing request mid-frame aborts the frame
// - End writes vector, then clears request and flags done
// - Abort and late collision shown in status
// - Vector fields written low byte first
// - Bits 55-52 and 31 always zero
// - Bit 51 for VLAN type 8100h
// - Bits 48-50 control, pause, backpressure
// - Wire bytes and frame bytes counted
// - Giant, late and excessive collision bits
// - Excessive defer and deferred bits
// - Broadcast, multicast and done bits
// - Length range, length check, CRC error bits
// - Collision count only for sent packets
// - Pad short frames to 60 bytes
// - Without huge allowance abort at max length
`timescale 1ns/1ps
`default_nettype none
`include "tx_seq_map.svh"
module tx_seq_device #(
	parameter int ADDR_W       = `BUF_ADDR_W,
	parameter int DEFER_CYCLES = `EXCESS_DEFER_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	tx_link.device          link,
	input  wire logic       collision_pin,
	input  wire logic       carrier_pin,
	input  wire logic       backpressure_pin,
	input  wire logic       dma_finished,
	output logic [7:0]      wire_byte,
	output logic            wire_valid,
	output logic            dma_grant
);
	if (ADDR_W != `BUF_ADDR_W || DEFER_CYCLES < 2) begin : g_check
		$error("Unsupported tx_seq_device parameters");
	end

	logic [7:0]               mem [0:(1<<ADDR_W)-1];
	tx_seq_pkg::tx_state_type state;
	tx_seq_pkg::tx_status_type sv;
	logic [2:0]  sync1, sync2, sync3, pin_lvl;
	logic        col_prev, col_event;
	logic        take, wr_reg, tx_request, dma_start, finish, aborted, cancel;
	logic        tx_done_flag, tx_abort_status, late_collision_status;
	logic [7:0]  irq_en, frame_cfg, ctrl_byte, cur, out_byte;
	logic [3:0]  retry_limit;
	logic [5:0]  col_window;
	logic [15:0] max_len, frame_cnt, wire_cnt, data_cnt, type_field, opcode;
	logic [ADDR_W-1:0] start_ptr, end_ptr, rd_ptr;
	logic [4:0]  coll_cnt;
	logic [31:0] crc, defer_cnt;
	logic [2:0]  sub;
	logic        bcast_acc, mcast_acc, crc_en, pad_en, huge_en;

	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// Agreement of the last two stages filters single-cycle glitches on the pins
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			sync3 <= 3'h0;
			pin_lvl <= 3'h0;
			col_prev <= 1'b0;
		end else begin
			sync1 <= {backpressure_pin, carrier_pin, collision_pin};
			sync2 <= sync1;
			sync3 <= sync2;
			pin_lvl <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & pin_lvl);
			col_prev <= pin_lvl[0];
		end
	end

	assign col_event = pin_lvl[0] & ~col_prev;
	assign take = link.req & ~link.ack;
	assign wr_reg = take && link.op == `OP_REG_WR;
	assign crc_en = ctrl_byte[`PP_OVERRIDE] ? ctrl_byte[`PP_CRC] : frame_cfg[`CFG_CRC];
	assign pad_en = ctrl_byte[`PP_OVERRIDE] ? ctrl_byte[`PP_PAD] : |frame_cfg[`CFG_PAD_HI:`CFG_PAD_LO];
	assign huge_en = ctrl_byte[`PP_OVERRIDE] ? ctrl_byte[`PP_HUGE] : frame_cfg[`CFG_HUGE];
	assign cancel = (state == tx_seq_pkg::DEFER || state == tx_seq_pkg::SEND || state == tx_seq_pkg::PAD
		|| state == tx_seq_pkg::CRC) && !tx_request;
	assign cur = mem[rd_ptr];

	always_comb begin
		unique case (state)
			tx_seq_pkg::SEND: out_byte = cur;
			tx_seq_pkg::CRC: out_byte = ~crc[{sub[1:0], 3'h0} +: 8];
			default: out_byte = 8'h00;
		endcase
	end

	// Register writes; hardware set of the done flag wins over a host clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_request <= 1'b0;
			dma_start <= 1'b0;
			dma_grant <= 1'b0;
			tx_done_flag <= 1'b0;
			irq_en <= 8'h00;
			start_ptr <= '0;
			end_ptr <= '0;
			frame_cfg <= `CFG_RESET;
			retry_limit <= `RETRY_RESET;
			col_window <= `COLWIN_RESET;
			max_len <= `MAXLEN_RESET;
		end else begin
			if (wr_reg && link.addr == `REG_CTRL) begin
				tx_request <= link.wdata[`CTRL_TX_REQUEST];
				dma_start <= link.wdata[`CTRL_DMA_START];
			end else begin
				if (finish)
					tx_request <= 1'b0;
				if (dma_finished && dma_grant)
					dma_start <= 1'b0;
			end
			if (dma_finished)
				dma_grant <= 1'b0;
			else if (dma_start && !tx_request && state == tx_seq_pkg::IDLE)
				dma_grant <= 1'b1;
			if (finish)
				tx_done_flag <= 1'b1;
			else if (wr_reg && link.addr == `REG_IRQ_FLAG)
				tx_done_flag <= link.wdata[`IRQ_TX_DONE];
			if (wr_reg) begin
				unique case (link.addr)
					`REG_IRQ_EN: irq_en <= link.wdata;
					`REG_START_LO: start_ptr[7:0] <= link.wdata;
					`REG_START_HI: start_ptr[ADDR_W-1:8] <= link.wdata[ADDR_W-9:0];
					`REG_END_LO: end_ptr[7:0] <= link.wdata;
					`REG_END_HI: end_ptr[ADDR_W-1:8] <= link.wdata[ADDR_W-9:0];
					`REG_FRAME_CFG: frame_cfg <= link.wdata;
					`REG_RETRY: retry_limit <= link.wdata[3:0];
					`REG_COLWIN: col_window <= link.wdata[5:0];
					`REG_MAXLEN_LO: max_len[7:0] <= link.wdata;
					`REG_MAXLEN_HI: max_len[15:8] <= link.wdata;
					default: ;
				endcase
			end
		end
	end

	// Link answer one cycle after each taken request; interrupt level registered every cycle from the done flag and enables
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link.ack <= 1'b0;
			link.rdata <= 8'h00;
			link.irq <= 1'b0;
		end else begin
			link.ack <= take;
			link.irq <= tx_done_flag & irq_en[`IRQ_TX_DONE] & irq_en[`EN_GLOBAL];
			if (take && link.op == `OP_BUF_RD)
				link.rdata <= mem[link.addr];
			else if (take && link.op == `OP_REG_RD) begin
				unique case (link.addr)
					`REG_CTRL: link.rdata <= {2'h0, dma_start, 1'b0, tx_request, 3'h0};
					`REG_IRQ_FLAG: link.rdata <= {4'h0, tx_done_flag, 3'h0};
					`REG_IRQ_EN: link.rdata <= irq_en;
					`REG_STATUS: link.rdata <= {3'h0, late_collision_status, 2'h0, tx_abort_status, 1'b0};
					`REG_START_LO: link.rdata <= start_ptr[7:0];
					`REG_START_HI: link.rdata <= 8'(start_ptr[ADDR_W-1:8]);
					`REG_END_LO: link.rdata <= end_ptr[7:0];
					`REG_END_HI: link.rdata <= 8'(end_ptr[ADDR_W-1:8]);
					`REG_FRAME_CFG: link.rdata <= frame_cfg;
					`REG_RETRY: link.rdata <= {4'h0, retry_limit};
					`REG_COLWIN: link.rdata <= {2'h0, col_window};
					`REG_MAXLEN_LO: link.rdata <= max_len[7:0];
					`REG_MAXLEN_HI: link.rdata <= max_len[15:8];
					default: link.rdata <= 8'h00;
				endcase
			end
		end
	end

	// Shared memory port: the status vector write owns it while it runs
	always_ff @(posedge clk) begin
		if (state == tx_seq_pkg::STATUS)
			mem[ADDR_W'(end_ptr + 1'b1 + sub)] <= sv[{sub, 3'h0} +: 8];
		else if (take && link.op == `OP_BUF_WR)
			mem[link.addr] <= link.wdata;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= tx_seq_pkg::IDLE;
			sv <= '0;
			ctrl_byte <= 8'h00;
			rd_ptr <= '0;
			frame_cnt <= 16'h0000;
			wire_cnt <= 16'h0000;
			data_cnt <= 16'h0000;
			type_field <= 16'h0000;
			opcode <= 16'h0000;
			coll_cnt <= 5'h00;
			defer_cnt <= 32'h00000000;
			crc <= `CRC_INIT;
			sub <= 3'h0;
			bcast_acc <= 1'b0;
			mcast_acc <= 1'b0;
			aborted <= 1'b0;
			finish <= 1'b0;
			wire_byte <= 8'h00;
			wire_valid <= 1'b0;
			tx_abort_status <= 1'b0;
			late_collision_status <= 1'b0;
		end else begin
			wire_valid <= 1'b0;
			finish <= 1'b0;
			unique case (state)
				tx_seq_pkg::IDLE: begin
					if (tx_request && !dma_grant && !finish) begin
						ctrl_byte <= mem[start_ptr];
						rd_ptr <= ADDR_W'(start_ptr + 1'b1);
						sv <= '0;
						frame_cnt <= 16'h0000;
						wire_cnt <= 16'h0000;
						coll_cnt <= 5'h00;
						defer_cnt <= 32'h00000000;
						crc <= `CRC_INIT;
						sub <= 3'h0;
						aborted <= 1'b0;
						tx_abort_status <= 1'b0;
						late_collision_status <= 1'b0;
						state <= tx_seq_pkg::DEFER;
					end
				end
				tx_seq_pkg::DEFER: begin
					if (pin_lvl[2])
						sv.backpressure <= 1'b1;
					if (cancel) begin
						aborted <= 1'b1;
						state <= tx_seq_pkg::FILL;
					end else if (pin_lvl[1]) begin
						defer_cnt <= defer_cnt + 1'b1;
						sv.deferred <= 1'b1;
						if (defer_cnt == 32'(DEFER_CYCLES - 1)) begin
							sv.excess_defer <= 1'b1;
							sv.deferred <= 1'b0;
							aborted <= 1'b1;
							state <= tx_seq_pkg::FILL;
						end
					end else
						state <= tx_seq_pkg::SEND;
				end
				tx_seq_pkg::SEND, tx_seq_pkg::PAD, tx_seq_pkg::CRC: begin
					if (cancel) begin
						aborted <= 1'b1;
						state <= tx_seq_pkg::FILL;
					end else if (col_event) begin
						coll_cnt <= coll_cnt + 1'b1;
						if (frame_cnt > {10'h000, col_window}) begin
							sv.late_col <= 1'b1;
							aborted <= 1'b1;
							state <= tx_seq_pkg::FILL;
						end else if (coll_cnt >= {1'b0, retry_limit}) begin
							sv.excess_col <= 1'b1;
							aborted <= 1'b1;
							state <= tx_seq_pkg::FILL;
						end else begin
							// Retry from the first header byte after deferring again
							rd_ptr <= ADDR_W'(start_ptr + 1'b1);
							frame_cnt <= 16'h0000;
							crc <= `CRC_INIT;
							sub <= 3'h0;
							state <= tx_seq_pkg::DEFER;
						end
					end else if (state == tx_seq_pkg::SEND && frame_cnt >= max_len && !huge_en) begin
						sv.giant <= 1'b1;
						aborted <= 1'b1;
						state <= tx_seq_pkg::FILL;
					end else begin
						wire_byte <= out_byte;
						wire_valid <= 1'b1;
						frame_cnt <= frame_cnt + 1'b1;
						wire_cnt <= wire_cnt + 1'b1;
						if (state != tx_seq_pkg::CRC)
							crc <= crc_step(crc, out_byte);
						if (state == tx_seq_pkg::SEND) begin
							if (frame_cnt >= max_len)
								sv.giant <= 1'b1;
							if (frame_cnt == 16'h0000)
								mcast_acc <= cur[0];
							if (frame_cnt < 16'h0006)
								bcast_acc <= (frame_cnt == 16'h0000 || bcast_acc) && cur == 8'hFF;
							if (frame_cnt == 16'h000C || frame_cnt == 16'h000D)
								type_field <= {type_field[7:0], cur};
							if (frame_cnt == 16'h000E || frame_cnt == 16'h000F)
								opcode <= {opcode[7:0], cur};
							rd_ptr <= ADDR_W'(rd_ptr + 1'b1);
						end
						if (state == tx_seq_pkg::SEND && rd_ptr == end_ptr) begin
							data_cnt <= frame_cnt + 1'b1;
							if (!crc_en)
								sv.crc_err <= crc_step(crc, cur) != `CRC_RESIDUE;
						end
						if ((state == tx_seq_pkg::SEND && rd_ptr == end_ptr) || state == tx_seq_pkg::PAD) begin
							if (pad_en && frame_cnt + 1'b1 < `MIN_FRAME)
								state <= tx_seq_pkg::PAD;
							else if (crc_en)
								state <= tx_seq_pkg::CRC;
							else
								state <= tx_seq_pkg::FILL;
						end
						if (state == tx_seq_pkg::CRC) begin
							sub <= sub + 1'b1;
							if (sub == 3'h3) begin
								sub <= 3'h0;
								state <= tx_seq_pkg::FILL;
							end
						end
					end
				end
				tx_seq_pkg::FILL: begin
					sv.byte_count <= frame_cnt;
					sv.wire_bytes <= wire_cnt;
					sv.coll_count <= aborted ? 4'h0 : coll_cnt[3:0];
					sv.done <= !aborted;
					sv.bcast <= bcast_acc;
					sv.mcast <= mcast_acc & !bcast_acc;
					sv.vlan <= type_field == `VLAN_ID;
					sv.control <= type_field == `CTRL_TYPE;
					sv.pause <= type_field == `CTRL_TYPE && opcode == `PAUSE_OPCODE;
					sv.len_range <= type_field > `MAX_LEN_FIELD;
					sv.len_err <= frame_cfg[`CFG_LEN_CHECK] && type_field <= `MAX_LEN_FIELD
						&& type_field != data_cnt - `HDR_BYTES;
					sub <= 3'h0;
					state <= tx_seq_pkg::STATUS;
				end
				tx_seq_pkg::STATUS: begin
					sub <= sub + 1'b1;
					if (sub == `STATUS_LAST) begin
						finish <= 1'b1;
						tx_abort_status <= aborted;
						late_collision_status <= sv.late_col;
						state <= tx_seq_pkg::IDLE;
					end
				end
				default: state <= tx_seq_pkg::IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- tx_seq_map.svh
`ifndef TX_SEQ_MAP_SVH
`define TX_SEQ_MAP_SVH
`define BUF_ADDR_W        13
`define OP_REG_WR         2'h0
`define OP_REG_RD         2'h1
`define OP_BUF_WR         2'h2
`define OP_BUF_RD         2'h3
`define REG_CTRL          13'h0000
`define REG_IRQ_FLAG      13'h0001
`define REG_IRQ_EN        13'h0002
`define REG_STATUS        13'h0003
`define REG_START_LO      13'h0004
`define REG_START_HI      13'h0005
`define REG_END_LO        13'h0006
`define REG_END_HI        13'h0007
`define REG_FRAME_CFG     13'h0008
`define REG_RETRY         13'h0009
`define REG_COLWIN        13'h000A
`define REG_MAXLEN_LO     13'h000B
`define REG_MAXLEN_HI     13'h000C
`define CTRL_TX_REQUEST   3
`define CTRL_DMA_START    5
`define IRQ_TX_DONE       3
`define EN_GLOBAL         7
`define STAT_ABORT        1
`define STAT_LATE_COL     4
`define CFG_PAD_HI        7
`define CFG_PAD_LO        5
`define CFG_CRC           4
`define CFG_HUGE          2
`define CFG_LEN_CHECK     1
`define PP_OVERRIDE       0
`define PP_CRC            1
`define PP_PAD            2
`define PP_HUGE           3
`define CFG_RESET         8'h00
`define RETRY_RESET       4'hF
`define COLWIN_RESET      6'h37
`define MAXLEN_RESET      16'h05EE
`define MIN_FRAME         16'h003C
`define HDR_BYTES         16'h000E
`define MAX_LEN_FIELD     16'h05DC
`define VLAN_ID           16'h8100
`define CTRL_TYPE         16'h8808
`define PAUSE_OPCODE      16'h0001
`define CRC_INIT          32'hFFFFFFFF
`define CRC_POLY          32'hEDB88320
`define CRC_RESIDUE       32'hDEBB20E3
`define STATUS_LAST       3'h6
`define CLK_PERIOD_NS     10
`define EXCESS_DEFER_NS   2428700
`define EXCESS_DEFER_CYCLES (`EXCESS_DEFER_NS / `CLK_PERIOD_NS)
`define WB_CMD_ADDR       3'h0
`define WB_CMD_DATA       3'h1
`define WB_CMD_GO         3'h2
`define WB_STATUS         3'h3
`endif

//--- tx_seq_pkg.sv
`default_nettype none
package tx_seq_pkg;
	typedef enum logic [2:0] {
		IDLE   = 3'b000,
		DEFER  = 3'b001,
		SEND   = 3'b010,
		PAD    = 3'b011,
		CRC    = 3'b100,
		FILL   = 3'b101,
		STATUS = 3'b110
	} tx_state_type;

	typedef struct packed {
		logic [3:0]  zero;
		logic        vlan;
		logic        backpressure;
		logic        pause;
		logic        control;
		logic [15:0] wire_bytes;
		logic        underrun;
		logic        giant;
		logic        late_col;
		logic        excess_col;
		logic        excess_defer;
		logic        deferred;
		logic        bcast;
		logic        mcast;
		logic        done;
		logic        len_range;
		logic        len_err;
		logic        crc_err;
		logic [3:0]  coll_count;
		logic [15:0] byte_count;
	} tx_status_type;
endpackage
`default_nettype wire

//--- tx_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_seq_map.svh"
interface tx_link;
	logic                   req;
	logic [1:0]             op;
	logic [`BUF_ADDR_W-1:0] addr;
	logic [7:0]             wdata;
	logic                   ack;
	logic [7:0]             rdata;
	logic                   irq;
	modport device (input req, input op, input addr, input wdata, output ack, output rdata, output irq);
	modport host (output req, output op, output addr, output wdata, input ack, input rdata, input irq);
endinterface
`default_nettype wire

//--- tx_seq_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_seq_map.svh"
module tx_seq_host (
	input  wire logic        clk,
	input  wire logic        reset_n,
	tx_link.host             link,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq
);
	logic [`BUF_ADDR_W-1:0] cmd_addr;
	logic [7:0]             cmd_data, rdata;
	logic                   commit;

	// A write commits on the edge where the master sees ack high
	assign commit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				unique case (wb_adr_i[4:2])
					`WB_CMD_ADDR: wb_dat_o <= {19'h00000, cmd_addr};
					`WB_CMD_DATA: wb_dat_o <= {24'h000000, cmd_data};
					`WB_STATUS: wb_dat_o <= {16'h0000, rdata, 6'h00, irq, link.req};
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_addr <= '0;
			cmd_data <= 8'h00;
		end else if (commit) begin
			if (wb_adr_i[4:2] == `WB_CMD_ADDR && wb_sel_i[0])
				cmd_addr[7:0] <= wb_dat_i[7:0];
			if (wb_adr_i[4:2] == `WB_CMD_ADDR && wb_sel_i[1])
				cmd_addr[`BUF_ADDR_W-1:8] <= wb_dat_i[`BUF_ADDR_W-1:8];
			if (wb_adr_i[4:2] == `WB_CMD_DATA && wb_sel_i[0])
				cmd_data <= wb_dat_i[7:0];
		end
	end

	// One command in flight; a start while busy is dropped, software polls busy
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link.req <= 1'b0;
			link.op <= 2'h0;
			link.addr <= '0;
			link.wdata <= 8'h00;
			rdata <= 8'h00;
			irq <= 1'b0;
		end else begin
			irq <= link.irq;
			if (link.req && link.ack) begin
				link.req <= 1'b0;
				rdata <= link.rdata;
			end else if (!link.req && commit && wb_adr_i[4:2] == `WB_CMD_GO && wb_sel_i[0]) begin
				link.req <= 1'b1;
				link.op <= wb_dat_i[1:0];
				link.addr <= cmd_addr;
				link.wdata <= cmd_data;
			end
		end
	end
endmodule
`default_nettype wire

//--- tx_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tx_link_sva (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        req,
	input wire logic [1:0]  op,
	input wire logic [12:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        ack,
	input wire logic [7:0]  rdata,
	input wire logic        wire_valid,
	input wire logic        dma_grant,
	input wire logic        dma_finished
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence take_s;
		req && !ack;
	endsequence
	sequence answer_s;
		ack ##1 !ack;
	endsequence
	ack_timing_a: assert property ($rose(req) |-> take_s ##1 answer_s)
		else $error("link ack not one cycle after request");
	ack_cause_a: assert property (ack |-> $past(req) && !$past(ack))
		else $error("link ack without a pending request");
	req_hold_a: assert property (req && !ack |=> req && $stable(op) && $stable(addr) && $stable(wdata))
		else $error("link request changed before ack");
	req_release_a: assert property (ack |=> !req)
		else $error("link request not released after ack");
	rdata_hold_a: assert property ($changed(rdata) |-> ack)
		else $error("link read data changed outside ack");
	dma_wire_a: assert property (dma_grant |-> !wire_valid)
		else $error("frame byte sent while dma owns memory");
	grant_hold_a: assert property (dma_grant && !dma_finished |=> dma_grant)
		else $error("dma grant dropped before dma finished");
	grant_release_a: assert property (dma_grant && dma_finished |=> !dma_grant)
		else $error("dma grant kept after dma finished");
endmodule
`default_nettype wire

//--- packet_transmit_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_seq_map.svh"
module packet_transmit_sequencer_tb;
	typedef struct packed {
		logic [1:0]  op;
		logic [12:0] addr;
		logic [7:0]  wd;
		logic [7:0]  ev;
	} row_type;
	logic        clk, reset_n, wb_cyc, wb_stb, wb_we, wb_ack, hirq;
	logic        col, car, bp, dfin, wvalid, grant;
	logic [31:0] wb_adr, wb_dat, wb_rdat, w, cr;
	logic [3:0]  wb_sel;
	logic [7:0]  wbyte, d;
	logic [55:0] sv;
	logic [7:0]  wq[$];
	int          errors, n_compared, cycles;
	localparam logic [7:0] FR[16] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h02, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02, 8'hAA, 8'h55};
	row_type rows[14] = '{{2'h1, `REG_FRAME_CFG, 8'h00, 8'h00}, {2'h1, `REG_RETRY, 8'h00, 8'h0F},
		{2'h1, `REG_COLWIN, 8'h00, 8'h37}, {2'h1, `REG_MAXLEN_LO, 8'h00, 8'hEE},
		{2'h1, `REG_MAXLEN_HI, 8'h00, 8'h05}, {2'h1, `REG_CTRL, 8'h00, 8'h00},
		{2'h0, `REG_START_LO, 8'h00, 8'h00}, {2'h0, `REG_START_HI, 8'h01, 8'h00},
		{2'h0, `REG_END_LO, 8'h10, 8'h00}, {2'h0, `REG_END_HI, 8'h01, 8'h00},
		{2'h0, `REG_IRQ_EN, 8'h88, 8'h00}, {2'h1, `REG_IRQ_EN, 8'h00, 8'h88},
		{2'h0, `REG_RETRY, 8'h03, 8'h00}, {2'h1, `REG_RETRY, 8'h00, 8'h03}};
	tx_link lnk();
	tx_seq_device #(.DEFER_CYCLES(400)) u_tx_seq_device (.clk(clk), .reset_n(reset_n), .link(lnk),
		.collision_pin(col), .carrier_pin(car), .backpressure_pin(bp), .dma_finished(dfin),
		.wire_byte(wbyte), .wire_valid(wvalid), .dma_grant(grant));
	tx_seq_host u_tx_seq_host (.clk(clk), .reset_n(reset_n), .link(lnk), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq(hirq));
	tx_link_sva u_tx_link_sva (.clk(clk), .reset_n(reset_n), .req(lnk.req), .op(lnk.op),
		.addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata), .wire_valid(wvalid),
		.dma_grant(grant), .dma_finished(dfin));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		if (wvalid === 1'b1) wq.push_back(wbyte);
	end
	task report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end
	task chk(input string what, input logic [31:0] seen, input logic [31:0] ev);
		n_compared++;
		if (seen !== ev) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, ev, seen);
		end
	endtask
	task automatic wbc(input logic we, input logic [31:0] a, input logic [31:0] v, input logic [3:0] s,
		output logic [31:0] r);
		int n;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= v;
		wb_sel <= s;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		r = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	// One device access: address, data, go, then poll busy
	task automatic lk(input logic [1:0] op, input logic [12:0] a, input logic [7:0] v, output logic [7:0] r);
		int n;
		wbc(1'b1, 32'h0, {19'h0, a}, 4'h3, w);
		wbc(1'b1, 32'h4, {24'h0, v}, 4'h1, w);
		wbc(1'b1, 32'h8, {30'h0, op}, 4'h1, w);
		n = 0;
		do begin
			wbc(1'b0, 32'hC, 32'h0, 4'hF, w);
			n++;
		end while (w[0] !== 1'b0 && n < 20);
		r = w[15:8];
	endtask
	task prep(input logic [7:0] c);
		wq.delete();
		lk(2'h2, 13'h100, c, d);
		lk(2'h0, `REG_IRQ_FLAG, 8'h00, d);
	endtask
	task automatic fin();
		int n;
		n = 0;
		do begin
			lk(2'h1, `REG_IRQ_FLAG, 8'h00, d);
			n++;
		end while (d[3] !== 1'b1 && n < 40);
		chk("done flag", d[3], 1);
		for (int i = 0; i < 7; i++) begin
			lk(2'h3, 13'(32'h111 + i), 8'h00, d);
			sv[8*i +: 8] = d;
		end
	endtask
	function automatic logic [31:0] crc60();
		logic [31:0] c;
		c = `CRC_INIT;
		for (int i = 0; i < 60; i++) begin
			c = c ^ {24'h0, (i < 16) ? FR[i] : 8'h00};
			for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
		end
		return ~c;
	endfunction
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		{wb_cyc, wb_stb, wb_we, col, car, bp, dfin} = 7'h0;
		{wb_adr, wb_dat, wb_sel} = 68'h0;
		errors = 0;
		n_compared = 0;
		cycles = 0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		chk("wire_valid", wvalid, 0);
		chk("grant", grant, 0);
		chk("irq", hirq, 0);
		foreach (rows[i]) begin
			lk(rows[i].op, rows[i].addr, rows[i].wd, d);
			if (rows[i].op == 2'h1) chk("register", d, rows[i].ev);
		end
		wbc(1'b0, 32'h10, 32'h0, 4'hF, w);
		chk("unmapped", w, 0);
		for (int i = 0; i < 16; i++) lk(2'h2, 13'(32'h101 + i), FR[i], d);
		$display("test registers done");
		// Override with CRC and padding: short frame grows to 60 plus CRC
		prep(8'h07);
		lk(2'h0, `REG_CTRL, 8'h08, d);
		fin();
		chk("irq", w[1], 1);
		chk("wire count", wq.size(), 64);
		for (int i = 0; i < 60; i++) chk("wire byte", wq[i], (i < 16) ? FR[i] : 8'h00);
		cr = crc60();
		for (int i = 0; i < 4; i++) chk("crc byte", wq[60 + i], cr[8*i +: 8]);
		chk("zero nibble", sv[55:52], 0);
		chk("underrun", sv[31], 0);
		chk("done bit", sv[23], 1);
		chk("broadcast", sv[25], 1);
		chk("wire bytes", sv[47:32], 64);
		chk("frame bytes", sv[15:0], 64);
		chk("collisions", sv[19:16], 0);
		lk(2'h1, `REG_CTRL, 8'h00, d);
		chk("request bit", d[3], 0);
		lk(2'h1, `REG_END_LO, 8'h00, d);
		chk("end pointer", d, 8'h10);
		lk(2'h1, `REG_STATUS, 8'h00, d);
		chk("abort bit", d[1], 0);
		$display("test padded frame done");
		// Override off: per-packet CRC and pad bits must be ignored
		prep(8'h06);
		lk(2'h0, `REG_CTRL, 8'h08, d);
		fin();
		chk("wire count", wq.size(), 16);
		chk("wire bytes", sv[47:32], 16);
		chk("crc error", sv[20], 1);
		$display("test config frame done");
		// Control frame with pause opcode, then a VLAN tag in the type field
		lk(2'h2, 13'h10D, 8'h88, d);
		lk(2'h2, 13'h10E, 8'h08, d);
		lk(2'h2, 13'h10F, 8'h00, d);
		lk(2'h2, 13'h110, 8'h01, d);
		prep(8'h06);
		lk(2'h0, `REG_CTRL, 8'h08, d);
		fin();
		chk("control", sv[48], 1);
		chk("pause", sv[49], 1);
		chk("length range", sv[22], 1);
		chk("vlan", sv[51], 0);
		lk(2'h2, 13'h10D, 8'h81, d);
		lk(2'h2, 13'h10E, 8'h00, d);
		prep(8'h06);
		lk(2'h0, `REG_CTRL, 8'h08, d);
		fin();
		chk("vlan", sv[51], 1);
		chk("control", sv[48], 0);
		$display("test frame type done");
		prep(8'h06);
		lk(2'h0, `REG_CTRL, 8'h20, d);
		chk("grant", grant, 1);
		lk(2'h0, `REG_CTRL, 8'h28, d);
		repeat (30) @(posedge clk);
		chk("held by dma", wq.size(), 0);
		dfin <= 1'b1;
		@(posedge clk);
		dfin <= 1'b0;
		fin();
		chk("wire count", wq.size(), 16);
		$display("test dma wait done");
		// Busy medium keeps the frame in deferral, then the host cancels
		car <= 1'b1;
		bp <= 1'b1;
		prep(8'h07);
		lk(2'h0, `REG_CTRL, 8'h08, d);
		lk(2'h0, `REG_CTRL, 8'h00, d);
		car <= 1'b0;
		bp <= 1'b0;
		fin();
		chk("wire count", wq.size(), 0);
		chk("done bit", sv[23], 0);
		chk("backpressure", sv[50], 1);
		chk("deferred", sv[26], 1);
		chk("excess defer", sv[27], 0);
		lk(2'h1, `REG_STATUS, 8'h00, d);
		chk("abort bit", d[1], 1);
		$display("test cancel done");
		// Four early collisions against a retry limit of three abort the frame
		prep(8'h07);
		lk(2'h0, `REG_CTRL, 8'h08, d);
		repeat (5) begin
			col <= 1'b1;
			repeat (4) @(posedge clk);
			col <= 1'b0;
			repeat (4) @(posedge clk);
		end
		fin();
		chk("excess collision", sv[28], 1);
		chk("late collision", sv[29], 0);
		chk("collisions", sv[19:16], 0);
		chk("wire over frame", sv[47:32] > sv[15:0], 1);
		lk(2'h1, `REG_STATUS, 8'h00, d);
		chk("abort bit", d[1], 1);
		chk("late bit", d[4], 0);
		$display("test excess collision done");
		// A zero window makes any collision after the first sent byte late
		lk(2'h0, `REG_COLWIN, 8'h00, d);
		prep(8'h07);
		lk(2'h0, `REG_CTRL, 8'h08, d);
		col <= 1'b1;
		fin();
		col <= 1'b0;
		chk("late collision", sv[29], 1);
		chk("done bit", sv[23], 0);
		lk(2'h1, `REG_STATUS, 8'h00, d);
		chk("late bit", d[4], 1);
		chk("abort bit", d[1], 1);
		$display("test late collision done");
		lk(2'h0, `REG_MAXLEN_LO, 8'h0A, d);
		lk(2'h0, `REG_MAXLEN_HI, 8'h00, d);
		prep(8'h07);
		lk(2'h0, `REG_CTRL, 8'h08, d);
		fin();
		chk("giant", sv[30], 1);
		chk("wire count", wq.size(), 10);
		lk(2'h1, `REG_STATUS, 8'h00, d);
		chk("abort bit", d[1], 1);
		$display("test oversize done");
		report_and_stop();
	end
endmodule
`default_nettype wire
